// *** design/tic_chan.sv ***
// one capture channel: synchroniser, glitch filter, edge detector
// assumes the pin is a plain level; capture pulse is one cycle
`timescale 1ns/1ps
module tic_chan
	import tic_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and controls
	input wire logic pin,
	input wire logic en,
	input wire logic filt_en,
	input wire logic [1:0] edge_sel,
	// capture strobe
	output logic cap
);
	localparam logic [1:0] FILT_LAST = 2'(FILT_CLOCKS - 1);
	logic s1_r, s2_r, filt_r, prev_r, cap_r;
	logic [1:0] run_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin; // RULE_18
			s2_r <= s1_r;
		end
	end
	// new level must persist FILT_CLOCKS samples before it is believed
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_r <= 1'b0;
			run_r <= '0;
		end
		else if (!filt_en || s2_r == filt_r)
		begin
			filt_r <= s2_r;
			run_r <= '0;
		end
		else if (run_r == FILT_LAST) // RULE_06
		begin
			filt_r <= s2_r;
			run_r <= '0;
		end
		else
			run_r <= run_r + 1'b1;
	end
	wire lvl = filt_en ? filt_r : s2_r;
	wire rise = lvl & ~prev_r;
	wire fall = ~lvl & prev_r;
	// reserved code 11 never fires
	wire hit = (edge_sel == EDGE_RISE && rise) ||
		(edge_sel == EDGE_FALL && fall) ||
		(edge_sel == EDGE_BOTH && (rise || fall)); // RULE_07 RULE_14
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_r <= 1'b0;
			cap_r <= 1'b0;
		end
		else
		begin
			prev_r <= lvl;
			cap_r <= en && hit; // RULE_05
		end
	end
	assign cap = cap_r;
endmodule // tic_chan

// *** design/tic_pkg.sv ***
// constants shared by the timer-2 input capture block
// assumes a 20 MHz system clock and an AHB-Lite register bus
// Notes on behaviour
// RULE_01: reload/compare low byte holds low half of compare or reload value.
// RULE_02: reload/compare high byte holds high half of compare or reload value.
// RULE_03: software halts the timer before touching the counter bytes.
// RULE_04: select bit 1 means compare; else reload enable picks reload/capture.
// RULE_05: three channels, enables at bits 6..4 of capture control zero.
// RULE_06: enabled filter rejects input glitches shorter than 4 clocks.
// RULE_07: each channel detects falling, rising or both edges on one counter.
// RULE_08: a qualifying edge copies the 16-bit counter into that channel.
// RULE_09: a qualifying edge on channel n sets flag bit n.
// RULE_10: interrupt when a flag is set and both enables are one. Code also needs that flag's irqmask_r bit set.
// RULE_11: hardware never clears capture flags; software clears them.
// RULE_12: clear-after-capture zeroes the counter right after the snapshot.
// RULE_13: control, reload/compare and counter registers reset to zero.
// RULE_14: edge select 00 falling, 01 rising, 10 either, 11 reserved.
// RULE_15: counting only while run bit is one; clearing preserves the count.
// RULE_16: tick is system clock over 4, doubling per select step to 512.
// RULE_17: counter adds one per tick and wraps FFFF to 0000 as overflow.
// RULE_18: inputs are synchronised so each edge captures at most once.
package tic_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CAPCTL0 = 8'h92;
	localparam logic [7:0] IDX_EDGESEL = 8'h93;
	localparam logic [7:0] IDX_FILTCTL = 8'h94;
	localparam logic [7:0] IDX_TCTRL = 8'hC8;
	localparam logic [7:0] IDX_TMODE = 8'hC9;
	localparam logic [7:0] IDX_RCMP_LO = 8'hCA;
	localparam logic [7:0] IDX_RCMP_HI = 8'hCB;
	localparam logic [7:0] IDX_CNT_LO = 8'hCC;
	localparam logic [7:0] IDX_CNT_HI = 8'hCD;
	localparam logic [7:0] IDX_CAP0_LO = 8'hE4;
	localparam logic [7:0] IDX_CAP0_HI = 8'hE5;
	localparam logic [7:0] IDX_CAP1_LO = 8'hE6;
	localparam logic [7:0] IDX_CAP1_HI = 8'hE7;
	localparam logic [7:0] IDX_CAP2_LO = 8'hED;
	localparam logic [7:0] IDX_CAP2_HI = 8'hEE;
	localparam logic [7:0] IDX_IRQCTL = 8'hF0;
	localparam logic [7:0] IDX_IRQMASK = 8'hF1;
	// field positions
	localparam int CH_N = 3;
	localparam int POS_CAPEN = 4;
	localparam int POS_FILTEN = 4;
	localparam int POS_TOVF = 7;
	localparam int POS_RUN = 2;
	localparam int POS_CPRL = 0;
	localparam int POS_RLDEN = 7;
	localparam int POS_DIV = 4;
	localparam int POS_CAPCLR = 3;
	localparam int POS_GIE = 0;
	localparam int POS_CIE = 2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] CNT_CLEAR = 16'h0000;
	// edge select codes
	localparam logic [1:0] EDGE_FALL = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_BOTH = 2'b10;
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int FILT_CLOCKS = 4;
	localparam int PRESC_BASE = 4;
	localparam int PRESC_W = 9;
	typedef enum logic [1:0] {TIC_CAPTURE, TIC_RELOAD, TIC_COMPARE} tic_mode_e;
	function automatic tic_mode_e tic_mode(input logic cprl, input logic rlden);
		if (cprl)
			return TIC_COMPARE;
		return rlden ? TIC_RELOAD : TIC_CAPTURE;
	endfunction
endpackage

// *** design/tic_presc.sv ***
// timer tick divider: one-cycle tick every 4 << sel system clocks
// assumes run is a steady register bit from the owner
`timescale 1ns/1ps
module tic_presc
	import tic_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [2:0] sel,
	// tick out
	output logic tick
);
	logic [PRESC_W-1:0] cnt_r;
	logic tick_r;
	wire [PRESC_W-1:0] lim = PRESC_W'((PRESC_BASE << sel) - 1); // RULE_16
	wire wrap = (cnt_r >= lim);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			// halted divider keeps its phase
			if (run) // RULE_15
				cnt_r <= wrap ? '0 : cnt_r + 1'b1;
			tick_r <= run && wrap;
		end
	end
	assign tick = tick_r;
endmodule // tic_presc

// *** design/tic_top.sv ***
// timer-2 input capture unit with AHB-Lite register slave
// assumes one 20 MHz clock; capture pins may be asynchronous, each channel synchronises its pin
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tic_top
	import tic_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// capture pins
	input wire logic [CH_N-1:0] CAP_IN,
	// interrupt and status
	output logic IRQ,
	output logic [1:0] TIMER_MODE
);
	if (ADDR_W < 10 || ADDR_W > 32)
		$error("tic_top: ADDR_W must be 10..32");

	// registers
	logic [7:0] capctl_r, edgesel_r, filtctl_r, tctrl_r, tmode_r;
	logic [7:0] rcmp_lo_r, rcmp_hi_r, irqctl_r, irqmask_r;
	logic [15:0] cnt_r;
	logic [15:0] capv_r [CH_N];
	// bus pipeline
	logic wr_pend_r, rd_pend_r, ready_r;
	logic [ADDR_W-1:0] addr_r;
	logic [31:0] rdata_r;
	logic irq_r;
	logic [1:0] mode_r;

	// address phase
	wire take = HSEL && HTRANS[1] && HREADY;
	wire [7:0] a_idx = addr_r[9:2];
	wire a_ok = (addr_r[1:0] == 2'b00) &&
		(ADDR_W == 10 || addr_r[ADDR_W-1:(ADDR_W > 10 ? 10 : 9)] == '0);
	wire [7:0] wb = HWDATA[7:0];
	function automatic logic wr_hit(input logic [7:0] idx);
		return wr_pend_r && a_ok && a_idx == idx;
	endfunction
	wire w_capctl = wr_hit(IDX_CAPCTL0);
	wire w_tctrl = wr_hit(IDX_TCTRL);
	wire w_cnt_lo = wr_hit(IDX_CNT_LO);
	wire w_cnt_hi = wr_hit(IDX_CNT_HI);

	// channels and prescaler
	wire run = tctrl_r[POS_RUN];
	wire tick;
	wire [CH_N-1:0] cap_raw;
	tic_presc u_presc (
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.run(run),
		.sel(tmode_r[POS_DIV +: 3]),
		.tick(tick)
	);
	for (genvar i = 0; i < CH_N; i++)
	begin : g_ch
		tic_chan u_ch (
			.clk(CLK_SYS),
			.rst_n(RSTN),
			.pin(CAP_IN[i]),
			.en(capctl_r[POS_CAPEN + i]),
			.filt_en(filtctl_r[POS_FILTEN + i]),
			.edge_sel(edgesel_r[2*i +: 2]),
			.cap(cap_raw[i])
		);
	end

	// compare mode owns the counter; capture stands aside there
	wire tic_mode_e mode = tic_mode(tctrl_r[POS_CPRL], tmode_r[POS_RLDEN]); // RULE_04
	wire [CH_N-1:0] cap_ev = (mode != TIC_COMPARE) ? cap_raw : '0;
	wire any_cap = |cap_ev;
	wire ovf = tick && (cnt_r == 16'hFFFF); // RULE_17

	// counter: capture clear beats bus write beats tick
	wire [15:0] cnt_nxt =
		(any_cap && tmode_r[POS_CAPCLR]) ? CNT_CLEAR : // RULE_12
		w_cnt_lo ? {cnt_r[15:8], wb} :
		w_cnt_hi ? {wb, cnt_r[7:0]} :
		tick ? cnt_r + 16'h0001 : cnt_r; // RULE_15 RULE_17
	// software writes one to clear; a new event in that cycle still sets
	wire [CH_N-1:0] flag_clr = w_capctl ? wb[CH_N-1:0] : '0;
	wire [CH_N-1:0] flag_nxt =
		(capctl_r[CH_N-1:0] & ~flag_clr) | cap_ev; // RULE_09 RULE_11
	wire [7:0] capctl_nxt = w_capctl ?
		{1'b0, wb[POS_CAPEN +: CH_N], 1'b0, flag_nxt} :
		{capctl_r[7:CH_N], flag_nxt};
	wire tovf_nxt = (tctrl_r[POS_TOVF] &
		~(w_tctrl & wb[POS_TOVF])) | ovf;
	wire [7:0] tctrl_nxt = w_tctrl ?
		{tovf_nxt, 4'h0, wb[POS_RUN], 1'b0, wb[POS_CPRL]} :
		{tovf_nxt, tctrl_r[6:0]};
	wire irq_nxt = |(flag_nxt & irqmask_r[CH_N-1:0]) &&
		irqctl_r[POS_CIE] && irqctl_r[POS_GIE]; // RULE_10

	// read mux
	function automatic logic [7:0] rd_sel(input logic [7:0] idx);
		unique case (idx)
			IDX_CAPCTL0: return capctl_r;
			IDX_EDGESEL: return edgesel_r;
			IDX_FILTCTL: return filtctl_r;
			IDX_TCTRL: return tctrl_r;
			IDX_TMODE: return tmode_r;
			IDX_RCMP_LO: return rcmp_lo_r;
			IDX_RCMP_HI: return rcmp_hi_r;
			IDX_CNT_LO: return cnt_r[7:0];
			IDX_CNT_HI: return cnt_r[15:8];
			IDX_CAP0_LO: return capv_r[0][7:0];
			IDX_CAP0_HI: return capv_r[0][15:8];
			IDX_CAP1_LO: return capv_r[1][7:0];
			IDX_CAP1_HI: return capv_r[1][15:8];
			IDX_CAP2_LO: return capv_r[2][7:0];
			IDX_CAP2_HI: return capv_r[2][15:8];
			IDX_IRQCTL: return irqctl_r;
			IDX_IRQMASK: return irqmask_r;
			default: return RST_BYTE;
		endcase
	endfunction
	wire [31:0] rd_word = {24'h00_0000, a_ok ? rd_sel(a_idx) : RST_BYTE};

	// bus handshake; reads take one wait state so a prior write is seen
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			ready_r <= 1'b1;
			addr_r <= '0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wr_pend_r <= take && HWRITE;
			rd_pend_r <= take && !HWRITE;
			if (take)
				addr_r <= HADDR;
			ready_r <= !(take && !HWRITE);
			if (rd_pend_r)
				rdata_r <= rd_word;
		end
	end

	// control and configuration
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			capctl_r <= RST_BYTE; // RULE_13
			tctrl_r <= RST_BYTE;
			tmode_r <= RST_BYTE;
			edgesel_r <= RST_BYTE;
			filtctl_r <= RST_BYTE;
			irqctl_r <= RST_BYTE;
			irqmask_r <= RST_BYTE;
		end
		else
		begin
			capctl_r <= capctl_nxt; // RULE_05
			tctrl_r <= tctrl_nxt;
			if (wr_hit(IDX_TMODE))
				tmode_r <= wb;
			if (wr_hit(IDX_EDGESEL))
				edgesel_r <= {2'b00, wb[5:0]};
			if (wr_hit(IDX_FILTCTL))
				filtctl_r <= {1'b0, wb[POS_FILTEN +: CH_N], 4'h0};
			if (wr_hit(IDX_IRQCTL))
				irqctl_r <= {5'h00, wb[POS_CIE], 1'b0, wb[POS_GIE]};
			if (wr_hit(IDX_IRQMASK))
				irqmask_r <= {5'h00, wb[CH_N-1:0]};
		end
	end

	// reload/compare value is only stored and read back; no compare or reload path uses it
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rcmp_lo_r <= RST_BYTE; // RULE_13
			rcmp_hi_r <= RST_BYTE;
			cnt_r <= CNT_CLEAR;
		end
		else
		begin
			if (wr_hit(IDX_RCMP_LO))
				rcmp_lo_r <= wb; // RULE_01
			if (wr_hit(IDX_RCMP_HI))
				rcmp_hi_r <= wb; // RULE_02
			// byte writes while running can tear the count
			cnt_r <= cnt_nxt;
		end
	end

	// snapshot takes the counter before any clear of the same cycle
	for (genvar i = 0; i < CH_N; i++)
	begin : g_cap
		wire [7:0] lo_idx = (i == 0) ? IDX_CAP0_LO :
			(i == 1) ? IDX_CAP1_LO : IDX_CAP2_LO;
		wire [7:0] hi_idx = (i == 0) ? IDX_CAP0_HI :
			(i == 1) ? IDX_CAP1_HI : IDX_CAP2_HI;
		always_ff @(posedge CLK_SYS or negedge RSTN)
		begin
			if (!RSTN)
				capv_r[i] <= CNT_CLEAR;
			else if (cap_ev[i])
				capv_r[i] <= cnt_r; // RULE_08
			else if (wr_hit(lo_idx))
				capv_r[i] <= {capv_r[i][15:8], wb};
			else if (wr_hit(hi_idx))
				capv_r[i] <= {wb, capv_r[i][7:0]};
		end
	end

	// outputs
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_r <= 1'b0;
			mode_r <= 2'b00;
		end
		else
		begin
			irq_r <= irq_nxt; // RULE_10
			mode_r <= mode;
		end
	end
	assign HRDATA = rdata_r;
	assign HREADYOUT = ready_r;
	assign HRESP = 1'b0;
	assign IRQ = irq_r;
	assign TIMER_MODE = mode_r;
endmodule // tic_top

// *** testbench/test_timer2_input_capture.sv ***
// self-checking bench for tic_top over AHB-Lite
// assumes tic_pulse drives the pins and HREADY loops back
`timescale 1ns/1ps
module test_timer2_input_capture
	import tic_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] want = 3'h0;
	logic [2:0] glt = 3'h0;
	logic [7:0] r;
	wire [2:0] pin;
	wire [31:0] hrdata;
	wire hready;
	wire irq;
	wire [1:0] mode;
	int fail_count = 0;
	int total_checks = 0;
	tic_top tic_top_i (.CLK_SYS(clk), .RSTN(rstn), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(), .CAP_IN(pin), .IRQ(irq),
		.TIMER_MODE(mode));
	tic_pulse tic_pulse_i (.want(want), .glt(glt), .pin(pin));
	always #25 clk = ~clk;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkr(input logic [7:0] g, input int lo, input int hi);
		total_checks++;
		if ((g >= lo && g <= hi) !== 1'b1)
		begin
			fail_count++;
			$display("BAD %0t got %h out of range", $time, g);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {2'h0, i, 2'h0};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata[7:0];
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		xf(1'b1, i, d);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		xf(1'b0, i, 8'h00);
		chk(r, e);
	endtask
	task automatic pulse(input int c, input logic v);
		want[c] <= v;
		repeat (16) @(posedge clk);
	endtask
	task automatic t_regs();
		logic [7:0] q [5] = '{IDX_CAPCTL0, IDX_RCMP_LO, IDX_RCMP_HI,
			IDX_CNT_LO, IDX_CNT_HI};
		foreach (q[k])
			rd(q[k], RST_BYTE);
		wr(IDX_RCMP_LO, 8'hA5);
		wr(IDX_RCMP_HI, 8'h5A);
		rd(IDX_RCMP_LO, 8'hA5);
		rd(IDX_RCMP_HI, 8'h5A);
		rd(8'h10, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_TCTRL, {7'h00, k[0]});
			wr(IDX_TMODE, {k[1], 7'h00});
			repeat (2) @(posedge clk);
			chk(mode, k[0] ? TIC_COMPARE : k[1] ? TIC_RELOAD : TIC_CAPTURE);
		end
		wr(IDX_TCTRL, 8'h00);
		wr(IDX_TMODE, 8'h00);
	endtask
	task automatic t_edge();
		logic [1:0] c [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
		wr(IDX_CNT_LO, 8'h34);
		wr(IDX_CNT_HI, 8'h12);
		wr(IDX_IRQMASK, 8'h07);
		wr(IDX_IRQCTL, 8'h05);
		foreach (c[k])
		begin
			wr(IDX_EDGESEL, {6'h00, c[k]});
			wr(IDX_CAPCTL0, 8'h17);
			pulse(0, 1'b1);
			rd(IDX_CAPCTL0, {7'h08, c[k] != EDGE_FALL});
			pulse(0, 1'b0);
			rd(IDX_CAPCTL0, 8'h11);
		end
		chk(irq, 8'h01);
		rd(IDX_CAP0_LO, 8'h34);
		rd(IDX_CAP0_HI, 8'h12);
		wr(IDX_IRQCTL, 8'h01);
		repeat (2) @(posedge clk);
		chk(irq, 8'h00);
		wr(IDX_IRQCTL, 8'h05);
		repeat (2) @(posedge clk);
		chk(irq, 8'h01);
		wr(IDX_CAPCTL0, 8'h11);
		rd(IDX_CAPCTL0, 8'h10);
		chk(irq, 8'h00);
	endtask
	task automatic t_chan();
		wr(IDX_CAPCTL0, 8'h07);
		pulse(2, 1'b1);
		pulse(2, 1'b0);
		rd(IDX_CAPCTL0, 8'h00);
		wr(IDX_FILTCTL, 8'h20);
		wr(IDX_EDGESEL, 8'h04);
		wr(IDX_CAPCTL0, 8'h20);
		glt[1] <= 1'b1;
		repeat (2) @(posedge clk);
		glt[1] <= 1'b0;
		pulse(1, 1'b0);
		rd(IDX_CAPCTL0, 8'h20);
		pulse(1, 1'b1);
		rd(IDX_CAPCTL0, 8'h22);
		rd(IDX_CAP1_HI, 8'h12);
		wr(IDX_TMODE, 8'h08);
		pulse(1, 1'b0);
		pulse(1, 1'b1);
		rd(IDX_CNT_LO, 8'h00);
		rd(IDX_CNT_HI, 8'h00);
	endtask
	task automatic t_run();
		logic [7:0] n;
		for (int s = 0; s < 2; s++)
		begin
			wr(IDX_CNT_LO, 8'h00);
			wr(IDX_TMODE, {1'b0, s[2:0], 4'h0});
			wr(IDX_TCTRL, 8'h04);
			repeat (64) @(posedge clk);
			wr(IDX_TCTRL, 8'h00);
			xf(1'b0, IDX_CNT_LO, 8'h00);
			chkr(r, (16 >> s) - 1, (16 >> s) + 2);
			n = r;
			repeat (20) @(posedge clk);
			rd(IDX_CNT_LO, n);
		end
		wr(IDX_CNT_LO, 8'hFF);
		wr(IDX_CNT_HI, 8'hFF);
		wr(IDX_TCTRL, 8'h04);
		repeat (12) @(posedge clk);
		wr(IDX_TCTRL, 8'h00);
		rd(IDX_CNT_HI, 8'h00);
		rd(IDX_TCTRL, 8'h80);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_edge();
		t_chan();
		t_run();
		print_verdict();
	end
	// well under a thousand cycles suffice; this only cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict();
	end
endmodule // test_timer2_input_capture
bind tic_top tic_top_monitor #(.ADDR_W(ADDR_W)) tic_top_monitor_i (
	.CLK_SYS(CLK_SYS), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .CAP_IN(CAP_IN), .IRQ(IRQ), .TIMER_MODE(TIMER_MODE));

// *** testbench/tic_pulse.sv ***
// far side: external pulse sources on the capture pins
// assumes bench requests change just after a rising edge
`timescale 1ns/1ps
module tic_pulse
(
	// requests
	input wire logic [2:0] want,
	input wire logic [2:0] glt,
	// pins
	output logic [2:0] pin
);
	// a glitch request flips the held level while it lasts
	assign pin = want ^ glt;
endmodule // tic_pulse

// *** testbench/tic_top_monitor.sv ***
// checker on the ports of tic_top
// assumes HREADY is HREADYOUT and one clock domain
`timescale 1ns/1ps
module tic_top_monitor
	import tic_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RSTN,
	// bus
	input wire logic HSEL,
	input wire logic [ADDR_W-1:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// pins and status
	input wire logic [CH_N-1:0] CAP_IN,
	input wire logic IRQ,
	input wire logic [1:0] TIMER_MODE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	wire take = HSEL && HTRANS[1] && HREADY;
	wire wr_take = take && HWRITE;
	logic wtc_r;
	logic wic_r;
	logic [3:0] wage_r;
	logic [3:0] page_r;
	logic [CH_N-1:0] cin_r;
	// ages saturate so a long quiet spell cannot wrap
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			wtc_r <= 1'b0;
			wic_r <= 1'b0;
			wage_r <= 4'hF;
			page_r <= 4'hF;
			cin_r <= '0;
		end
		else
		begin
			wtc_r <= wr_take && HADDR[9:2] == IDX_TCTRL;
			wic_r <= wr_take && HADDR[9:2] == IDX_IRQCTL;
			wage_r <= wr_take ? 4'h0 : wage_r + 4'(wage_r != 4'hF);
			page_r <= CAP_IN != cin_r ? 4'h0 : page_r + 4'(page_r != 4'hF);
			cin_r <= CAP_IN;
		end
	end
	property p_okay;
		HRESP == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_rd_wait;
		take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_nowait;
		wr_take |=> HREADYOUT;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_cmp;
		wtc_r && HWDATA[POS_CPRL] |-> ##[1:3] TIMER_MODE == TIC_COMPARE;
	endproperty
	a_cmp: assert property (p_cmp) else $error("no compare mode");
	property p_nocmp;
		wtc_r && !HWDATA[POS_CPRL] |-> ##[1:3] TIMER_MODE != TIC_COMPARE;
	endproperty
	a_nocmp: assert property (p_nocmp) else $error("stuck compare");
	property p_irq_off;
		wic_r && !(HWDATA[POS_GIE] && HWDATA[POS_CIE]) |-> ##[1:3] !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not gated");
	property p_irq_hold;
		$fell(IRQ) |-> wage_r < 4'h6;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("flag self clear");
	property p_irq_src;
		$rose(IRQ) |-> page_r < 4'hF || wage_r < 4'h6;
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq no cause");
endmodule // tic_top_monitor
